// File: rtl/scan_port_map.vh
// constants for the boundary-scan test port
`ifndef SCAN_PORT_MAP_VH
`define SCAN_PORT_MAP_VH
`define INS_EXTERNAL 4'h0
`define INS_SAMPLE 4'h1
`define INS_IDENT 4'h2
`define INS_CLAMP 4'h3
`define INS_FLOAT 4'h4
`define INS_PASS 4'hf
`define INS_CAPTURE_PAT 4'h1
`define IDENT_MARK 1'b1
`define ST_RESET 4'h0
`define ST_IDLE 4'h1
`define ST_SEL_DR 4'h2
`define ST_CAP_DR 4'h3
`define ST_SH_DR 4'h4
`define ST_EX1_DR 4'h5
`define ST_PA_DR 4'h6
`define ST_EX2_DR 4'h7
`define ST_UP_DR 4'h8
`define ST_SEL_IR 4'h9
`define ST_CAP_IR 4'ha
`define ST_SH_IR 4'hb
`define ST_EX1_IR 4'hc
`define ST_PA_IR 4'hd
`define ST_EX2_IR 4'he
`define ST_UP_IR 4'hf
`endif

// File: rtl/scan_sync.v
// two-flop synchroniser for link pins and functional input pins
`timescale 1ns/1ps
`default_nettype none
module scan_sync #(
    parameter W = 4
) (
    // clock
    input wire i_mclk,
    input wire i_srst,
    input wire i_ce,
    // data
    input wire [W-1:0] i_async,
    output reg [W-1:0] o_sync
);
    reg [W-1:0] meta_q;
    always @(posedge i_mclk) begin
        if (i_srst) begin
            meta_q <= {W{1'b0}};
            o_sync <= {W{1'b0}};
        end else if (i_ce) begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule // scan_sync
`default_nettype wire

// File: rtl/scan_tap_fsm.v
// test access state machine
`timescale 1ns/1ps
`default_nettype none
`include "scan_port_map.vh"
module scan_tap_fsm (
    // clock
    input wire i_mclk,
    input wire i_srst,
    input wire i_ce,
    // link events
    input wire i_rise,
    input wire i_mode,
    input wire i_link_rst_n,
    // state
    output reg [3:0] o_state
);
    reg [3:0] state_d;
    always @* begin
        state_d = o_state;
        case (o_state)
            `ST_RESET: state_d = i_mode ? `ST_RESET : `ST_IDLE;
            `ST_IDLE: state_d = i_mode ? `ST_SEL_DR : `ST_IDLE;
            `ST_SEL_DR: state_d = i_mode ? `ST_SEL_IR : `ST_CAP_DR;
            `ST_CAP_DR: state_d = i_mode ? `ST_EX1_DR : `ST_SH_DR;
            `ST_SH_DR: state_d = i_mode ? `ST_EX1_DR : `ST_SH_DR;
            `ST_EX1_DR: state_d = i_mode ? `ST_UP_DR : `ST_PA_DR;
            `ST_PA_DR: state_d = i_mode ? `ST_EX2_DR : `ST_PA_DR;
            `ST_EX2_DR: state_d = i_mode ? `ST_UP_DR : `ST_SH_DR;
            `ST_UP_DR: state_d = i_mode ? `ST_SEL_DR : `ST_IDLE;
            `ST_SEL_IR: state_d = i_mode ? `ST_RESET : `ST_CAP_IR;
            `ST_CAP_IR: state_d = i_mode ? `ST_EX1_IR : `ST_SH_IR;
            `ST_SH_IR: state_d = i_mode ? `ST_EX1_IR : `ST_SH_IR;
            `ST_EX1_IR: state_d = i_mode ? `ST_UP_IR : `ST_PA_IR;
            `ST_PA_IR: state_d = i_mode ? `ST_EX2_IR : `ST_PA_IR;
            `ST_EX2_IR: state_d = i_mode ? `ST_UP_IR : `ST_SH_IR;
            `ST_UP_IR: state_d = i_mode ? `ST_SEL_DR : `ST_IDLE;
            default: state_d = `ST_RESET;
        endcase
    end
    always @(posedge i_mclk) begin
        if (i_srst) begin
            o_state <= `ST_RESET;
        end else if (i_ce) begin
            if (!i_link_rst_n) begin
                o_state <= `ST_RESET;
            end else if (i_rise) begin
                o_state <= state_d;
            end
        end
    end
endmodule // scan_tap_fsm
`default_nettype wire

// File: rtl/boundary_scan_test_port.v
// boundary-scan test port top
`timescale 1ns/1ps
`default_nettype none
`include "scan_port_map.vh"
module boundary_scan_test_port #(
    parameter N_IN = 8,
    parameter N_OUT = 8,
    parameter [3:0] REV = 4'h1, // arbitrary value
    parameter [15:0] PART = 16'h1234, // arbitrary value
    parameter [10:0] VENDOR = 11'h055 // arbitrary value
) (
    // clock
    input wire i_mclk,
    input wire i_srst,
    input wire i_ce,
    // test link
    input wire i_tck,
    input wire i_tms,
    input wire i_tdi,
    input wire i_trst_n,
    output reg o_tdo,
    output reg o_tdo_oe,
    // functional pins
    input wire [N_IN-1:0] i_func_in,
    input wire [N_OUT-1:0] i_core_out,
    input wire i_core_oe,
    output reg [N_IN-1:0] o_core_in,
    output reg [N_OUT-1:0] o_pin_out,
    output reg o_pin_oe
);
    localparam NB = N_IN + N_OUT;
    // ------------------------------------------------------------
    // link sampling
    // ------------------------------------------------------------
    wire [3:0] link_s;
    wire [N_IN-1:0] func_s;
    reg tck_q;
    scan_sync #(.W(4)) u_link (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_ce(i_ce),
        .i_async({i_tck, i_tms, i_tdi, i_trst_n}),
        .o_sync(link_s)
    );
    scan_sync #(.W(N_IN)) u_func (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_ce(i_ce),
        .i_async(i_func_in),
        .o_sync(func_s)
    );
    wire tck_s = link_s[3];
    wire tms_s = link_s[2];
    wire tdi_s = link_s[1];
    wire trst_n_s = link_s[0];
    wire rise = tck_s & ~tck_q;
    wire fall = ~tck_s & tck_q;
    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    wire [3:0] state;
    scan_tap_fsm u_fsm (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_ce(i_ce),
        .i_rise(rise),
        .i_mode(tms_s),
        .i_link_rst_n(trst_n_s),
        .o_state(state)
    );
    // ------------------------------------------------------------
    // scan registers
    // ------------------------------------------------------------
    reg [3:0] ins_sh_q;
    reg [3:0] scan_instruction_q;
    reg scan_passthrough_cell_q;
    reg [31:0] part_identity_q;
    reg [NB-1:0] chain_q;
    reg [NB-1:0] upd_q;
    wire [31:0] ident = {REV, PART, VENDOR, `IDENT_MARK};
    wire sel_chain = (scan_instruction_q == `INS_EXTERNAL) ||
                     (scan_instruction_q == `INS_SAMPLE);
    wire sel_ident = (scan_instruction_q == `INS_IDENT);
    wire drive_cells = (scan_instruction_q == `INS_EXTERNAL) ||
                       (scan_instruction_q == `INS_CLAMP);
    wire float_out = (scan_instruction_q == `INS_FLOAT);
    reg serial_d;
    always @* begin
        serial_d = scan_passthrough_cell_q;
        if (state == `ST_SH_IR) begin
            serial_d = ins_sh_q[0];
        end else if (sel_chain) begin
            serial_d = chain_q[0];
        end else if (sel_ident) begin
            serial_d = part_identity_q[0];
        end
    end
    always @(posedge i_mclk) begin
        if (i_srst) begin
            tck_q <= 1'b0;
            ins_sh_q <= 4'h0;
            scan_instruction_q <= `INS_IDENT;
            scan_passthrough_cell_q <= 1'b0;
            part_identity_q <= 32'h0000_0000;
            chain_q <= {NB{1'b0}};
            upd_q <= {NB{1'b0}};
            o_tdo <= 1'b0;
            o_tdo_oe <= 1'b0;
            o_core_in <= {N_IN{1'b0}};
            o_pin_out <= {N_OUT{1'b0}};
            o_pin_oe <= 1'b0;
        end else if (i_ce) begin
            tck_q <= tck_s;
            if (state == `ST_RESET) begin
                scan_instruction_q <= `INS_IDENT;
            end
            if (rise) begin
                case (state)
                    `ST_CAP_IR: ins_sh_q <= `INS_CAPTURE_PAT;
                    `ST_SH_IR: ins_sh_q <= {tdi_s, ins_sh_q[3:1]};
                    `ST_UP_IR: scan_instruction_q <= ins_sh_q;
                    `ST_CAP_DR: begin
                        scan_passthrough_cell_q <= 1'b0;
                        part_identity_q <= ident;
                        if (sel_chain) begin
                            chain_q <= {i_core_out, func_s};
                        end
                    end
                    `ST_SH_DR: begin
                        scan_passthrough_cell_q <= tdi_s;
                        part_identity_q <= {tdi_s, part_identity_q[31:1]};
                        if (sel_chain) begin
                            chain_q <= {tdi_s, chain_q[NB-1:1]};
                        end
                    end
                    `ST_UP_DR: begin
                        if (sel_chain) begin
                            upd_q <= chain_q;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            if (fall) begin
                o_tdo <= serial_d;
                o_tdo_oe <= (state == `ST_SH_DR) ||
                            (state == `ST_SH_IR);
            end
            if (drive_cells) begin
                o_core_in <= upd_q[N_IN-1:0];
                o_pin_out <= upd_q[NB-1:N_IN];
                o_pin_oe <= 1'b1;
            end else begin
                o_core_in <= func_s;
                o_pin_out <= i_core_out;
                o_pin_oe <= float_out ? 1'b0 : i_core_oe;
            end
        end
    end
endmodule // boundary_scan_test_port
`default_nettype wire

// File: tb/scan_port_props.sv
// checker for the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none
module scan_port_props #(parameter int N_OUT = 8) (
    // clock and link
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_trst_n,
    // core and pins
    input wire logic [N_OUT-1:0] i_core_out,
    input wire logic i_core_oe,
    input wire logic o_tdo,
    input wire logic o_tdo_oe,
    input wire logic [N_OUT-1:0] o_pin_out,
    input wire logic o_pin_oe
);
    logic [7:0] tms_q;
    always_ff @(posedge i_mclk)
        tms_q <= (i_srst || !i_tms) ? 8'h00 : tms_q + {7'h0, ~&tms_q};
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    chk_rst_quiet: assert property (disable iff (1'b0)
        i_srst |=> !o_tdo_oe && !o_pin_oe && o_pin_out == '0)
        else $error("outputs live after reset");
    chk_tdo_fall: assert property ($changed(o_tdo) |-> !$past(i_tck,3))
        else $error("tdo moved off a fall");
    chk_oe_fall: assert property (
        $changed(o_tdo_oe) |-> !$past(i_tck,3)) else $error("oe off a fall");
    chk_shift_in: assert property ($rose(o_tdo_oe) |-> !$past(i_tms,8))
        else $error("tdo enabled outside shift");
    chk_trst_idle: assert property (!i_trst_n [*8] |-> !o_tdo_oe)
        else $error("tdo driven in link reset");
    chk_trst_ident: assert property (!i_trst_n [*8] |->
        o_pin_oe == $past(i_core_oe)) else $error("pin enable not core");
    chk_trst_pins: assert property (!i_trst_n [*8] |->
        o_pin_out == $past(i_core_out)) else $error("pins not core");
    chk_tms_reset: assert property (tms_q >= 8'h5a |-> !o_tdo_oe)
        else $error("tdo driven after mode reset");
    cover property ($rose(o_tdo_oe));
    cover property (!o_pin_oe && i_core_oe);
    cover property (tms_q == 8'h5a);
endmodule // scan_port_props
`default_nettype wire

// File: tb/scan_ctrl_model.sv
// test controller model driving the serial link
`timescale 1ns/1ps
`default_nettype none
module scan_ctrl_model (
    // clock reference and serial return
    input wire logic i_mclk,
    input wire logic i_tdo,
    // link pins
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi,
    output logic o_trst_n
);
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b0;
        o_trst_n = 1'b1;
    end
    // one 160 ns period, clock still between calls
    task automatic step(input logic ms, input logic di, output logic so);
        o_tms = ms;
        o_tdi = di;
        repeat (8) @(posedge i_mclk);
        #1 so = i_tdo;
        o_tck = 1'b1;
        repeat (8) @(posedge i_mclk);
        #1 o_tck = 1'b0;
    endtask
    // to idle by reset pin or held mode select
    task automatic idle(input logic by_pin);
        logic so;
        if (by_pin) begin
            o_trst_n = 1'b0;
            repeat (8) @(posedge i_mclk);
            #1 o_trst_n = 1'b1;
        end else begin
            repeat (6) step(1'b1, 1'b0, so);
        end
        step(1'b0, 1'b0, so);
    endtask
    // idle to shift and back, lsb first
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic so;
        dout = 32'h0;
        step(1'b1, 1'b0, so);
        if (ir) step(1'b1, 1'b0, so);
        step(1'b0, 1'b0, so);
        step(1'b0, 1'b0, so);
        for (int k = 0; k < n; k++) begin
            step(k == n - 1, din[k], so);
            dout[k] = so;
        end
        step(1'b1, 1'b0, so);
        step(1'b0, 1'b0, so);
    endtask
endmodule // scan_ctrl_model
`default_nettype wire

// File: tb/boundary_scan_test_port_tb.sv
// testbench for the boundary-scan test port
`timescale 1ns/1ps
`default_nettype none
module boundary_scan_test_port_tb;
    localparam logic [3:0] REV = 4'h6; // arbitrary value
    localparam logic [15:0] PART = 16'h4d2e; // arbitrary value
    localparam logic [10:0] VENDOR = 11'h1a3; // arbitrary value
    localparam logic [31:0] ID = {REV, PART, VENDOR, 1'b1};
    localparam logic [11:0] CODES = 12'h34f;
    localparam logic [2:0] COE = 3'b010;
    localparam logic [2:0] EOE = 3'b100;
    logic i_mclk = 1'b0;
    logic i_srst = 1'b1;
    logic i_core_oe = 1'b1;
    logic [7:0] i_func_in = 8'h3c;
    logic [7:0] i_core_out = 8'hc5;
    logic tck, tms, tdi, trst_n, o_tdo, o_tdo_oe, o_pin_oe;
    logic [7:0] o_core_in, o_pin_out;
    logic [31:0] got;
    int num_errors = 0;
    int n_tests = 0;
    always #5 i_mclk = ~i_mclk;
    boundary_scan_test_port #(.REV(REV), .PART(PART), .VENDOR(VENDOR))
        i_boundary_scan_test_port (.i_mclk(i_mclk), .i_srst(i_srst),
        .i_ce(1'b1), .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .i_trst_n(trst_n),
        .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .i_func_in(i_func_in),
        .i_core_out(i_core_out), .i_core_oe(i_core_oe), .o_core_in(o_core_in),
        .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe));
    scan_ctrl_model i_scan_ctrl_model (.i_mclk(i_mclk),
        .i_tdo(o_tdo_oe ? o_tdo : 1'bz), .o_tck(tck), .o_tms(tms),
        .o_tdi(tdi), .o_trst_n(trst_n));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #300000;
        num_errors++;
        report_and_stop();
    end
    initial begin
        repeat (10) @(posedge i_mclk);
        #1 i_srst = 1'b0;
        i_scan_ctrl_model.idle(1'b1);
        i_scan_ctrl_model.scan(1'b0, 32, 32'h0, got);
        check(got, ID);
        check(got[0], 1'b1);
        $display("identity test end");
        i_scan_ctrl_model.scan(1'b1, 4, 32'h1, got);
        check(got, 32'h1);
        i_scan_ctrl_model.scan(1'b0, 16, 32'h5aa5, got);
        check(got, {16'h0, i_core_out, i_func_in});
        check({o_pin_out, o_core_in}, {i_core_out, i_func_in});
        i_scan_ctrl_model.scan(1'b1, 4, 32'h0, got);
        check({o_pin_oe, o_pin_out, o_core_in}, 17'h1_5aa5);
        $display("sample and external test end");
        for (int k = 0; k < 3; k++) begin
            i_core_oe = COE[k];
            i_scan_ctrl_model.scan(1'b1, 4, {28'h0, CODES[k*4 +: 4]}, got);
            i_scan_ctrl_model.scan(1'b0, 8, 32'ha5, got);
            check(got, 32'h4a);
            check(o_pin_oe, EOE[k]);
            check(o_pin_out, k == 2 ? 8'h5a : i_core_out);
        end
        $display("passthrough codes test end");
        i_scan_ctrl_model.idle(1'b0);
        i_scan_ctrl_model.scan(1'b0, 32, 32'h0, got);
        check(got, ID);
        check(o_pin_oe, i_core_oe);
        $display("mode reset test end");
        i_scan_ctrl_model.scan(1'b1, 4, 32'hf, got);
        check(got, 32'h1);
        i_scan_ctrl_model.idle(1'b1);
        i_scan_ctrl_model.scan(1'b0, 32, 32'h0, got);
        check(got, ID);
        $display("pin reset test end");
        report_and_stop();
    end
endmodule // boundary_scan_test_port_tb
bind boundary_scan_test_port scan_port_props #(.N_OUT(N_OUT)) i_scan_port_props (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_tck(i_tck), .i_tms(i_tms),
    .i_trst_n(i_trst_n), .i_core_out(i_core_out), .i_core_oe(i_core_oe),
    .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .o_pin_out(o_pin_out),
    .o_pin_oe(o_pin_oe));
`default_nettype wire
